// [src/rsg_gate.sv]
// Scoreboard store-hazard check, release sequence and operating register gating.
`timescale 1ns/10ps
`include "rsg_defs.svh"
module rsg_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic iss_valid,
  input wire rsg_pkg::rsg_code_t iss_unit,
  input wire rsg_pkg::rsg_desig_t result_designator,
  input wire rsg_pkg::rsg_desig_t first_source_designator,
  input wire logic first_source_used,
  input wire rsg_pkg::rsg_desig_t second_source_designator,
  input wire logic second_source_used,
  input wire logic [15:0] rel_req,
  output logic [15:0] transmit,
  output logic [15:0] go_unit,
  output logic [2:0][4:0] read_tag,
  output logic [2:0][59:0] opnd_first,
  output logic [2:0][59:0] opnd_second,
  output logic [2:0][2:0] store_tag,
  input wire logic [2:0][59:0] trunk_result,
  input wire logic [5:0] hop_tag,
  input wire logic hop_accept,
  input wire logic hop_write,
  input wire rsg_pkg::rsg_word_t mem_rdata,
  output logic mem_exit_valid,
  output logic [3:0] mem_exit_tag,
  output logic [59:0] mem_wdata
);
  import rsg_pkg::*;

  // ****************************************************************
  // Scoreboard state
  // ****************************************************************
  logic [15:0] busy_r, rf1_r, rf2_r, u1_r, u2_r, done_r;
  rsg_desig_t res_r [16];
  rsg_desig_t s1_r [16];
  rsg_desig_t s2_r [16];
  rsg_code_t q1_r [16];
  rsg_code_t q2_r [16];
  rsg_code_t slot_r [24];
  rsg_word_t regf_r [24];
  logic en_r, err_r, pready_r, pslverr_r, mem_v_r;
  logic [31:0] prdata_r;
  logic [15:0] transmit_r, go_unit_r;
  logic [2:0][4:0] rtag_r;
  logic [2:0][59:0] op1_r, op2_r;
  logic [2:0][2:0] st_tag_r;
  rsg_desig_t st_d_r [3];
  logic [3:0] mem_tag_r;
  rsg_word_t mem_wd_r;

  rsg_hold_if hif ();

  function automatic logic [1:0] trunk_of(input rsg_code_t c);
    if (c == `RSG_CODE_INC1 || c == `RSG_CODE_INC2) begin
      return 2'd3;
    end else if (c == `RSG_CODE_SHIFT || c == `RSG_CODE_LADD || c == `RSG_CODE_ADD) begin
      return 2'd1;
    end else if (c > `RSG_CODE_SHIFT && c <= `RSG_CODE_MUL2) begin
      return 2'd2;
    end
    return 2'd0;
  endfunction

  function automatic logic [15:0] lowest(input logic [15:0] v);
    return v & (~v + 16'h0001);
  endfunction

  // ****************************************************************
  // Hazard check and release
  // ****************************************************************
  logic [23:0] wait_reg;
  logic [15:0] all_clear, fu_mask, rel_cand, fu_grant, chan_rel, rel_vec, ready;
  logic [2:0][15:0] go_t;
  logic [15:0] go_all;

  always_comb begin
    wait_reg = 24'h0;
    fu_mask = 16'h0;
    for (int u = 0; u < 16; u++) begin
      fu_mask[u] = trunk_of(4'(u)) != 2'd0;
      if (rf1_r[u] && u1_r[u]) wait_reg[s1_r[u]] = 1'b1;
      if (rf2_r[u] && u2_r[u]) wait_reg[s2_r[u]] = 1'b1;
    end
    for (int u = 0; u < 16; u++) begin
      all_clear[u] = !wait_reg[res_r[u]];
    end
    hif.x_clear = ~wait_reg[7:0];
    rel_cand = rel_req & busy_r & all_clear & fu_mask & {16{en_r}};
    // One functional unit releases per cycle so that each trunk carries one result.
    fu_grant = lowest(rel_cand);
    chan_rel = hif.move ? 16'(16'h0001 << (`RSG_CODE_CHAN + {1'b0, hif.move_idx})) : 16'h0;
    rel_vec = fu_grant | chan_rel;
    ready = busy_r & fu_mask & rf1_r & rf2_r & ~done_r;
    go_all = 16'h0;
    for (int t = 0; t < 3; t++) begin
      logic [15:0] tm;
      tm = 16'h0;
      for (int u = 0; u < 16; u++) begin
        tm[u] = trunk_of(4'(u)) == 2'(t + 1);
      end
      go_t[t] = lowest(ready & tm);
      go_all = go_all | go_t[t];
    end
  end

  // Issue loads the designators; flags set from pending codes and releases.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 16'h0;
      rf1_r <= 16'h0;
      rf2_r <= 16'h0;
      u1_r <= 16'h0;
      u2_r <= 16'h0;
      done_r <= 16'h0;
      for (int u = 0; u < 16; u++) begin
        res_r[u] <= 5'h00;
        s1_r[u] <= 5'h00;
        s2_r[u] <= 5'h00;
        q1_r[u] <= 4'h0;
        q2_r[u] <= 4'h0;
      end
    end else if (ce) begin
      for (int u = 0; u < 16; u++) begin
        if (iss_valid && iss_unit == 4'(u)) begin
          busy_r[u] <= 1'b1;
          res_r[u] <= result_designator;
          s1_r[u] <= first_source_designator;
          s2_r[u] <= second_source_designator;
          u1_r[u] <= first_source_used;
          u2_r[u] <= second_source_used;
          // A slot whose owner releases this very cycle counts as unreserved.
          q1_r[u] <= (!first_source_used || rel_vec[slot_r[first_source_designator]]) ?
            `RSG_CODE_NONE : slot_r[first_source_designator];
          q2_r[u] <= (!second_source_used || rel_vec[slot_r[second_source_designator]]) ?
            `RSG_CODE_NONE : slot_r[second_source_designator];
          rf1_r[u] <= 1'b0;
          rf2_r[u] <= 1'b0;
          done_r[u] <= 1'b0;
        end else begin
          if (rel_vec[u]) busy_r[u] <= 1'b0;
          if (go_t[0][u] || go_t[1][u] || go_t[2][u]) done_r[u] <= 1'b1;
          if (done_r[u] && go_unit_r[u]) begin
            rf1_r[u] <= 1'b0;
            rf2_r[u] <= 1'b0;
          end else if (busy_r[u] && fu_mask[u] && !done_r[u]) begin
            if (q1_r[u] == `RSG_CODE_NONE || rel_vec[q1_r[u]]) rf1_r[u] <= 1'b1;
            if (q2_r[u] == `RSG_CODE_NONE || rel_vec[q2_r[u]]) rf2_r[u] <= 1'b1;
          end
        end
      end
    end
  end

  // Reservation slots; a new reservation wins over a release in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < 24; r++) slot_r[r] <= `RSG_CODE_NONE;
    end else if (ce) begin
      for (int r = 0; r < 24; r++) begin
        if (iss_valid && result_designator == 5'(r)) begin
          slot_r[r] <= iss_unit;
        end else if (slot_r[r] != `RSG_CODE_NONE && rel_vec[slot_r[r]]) begin
          slot_r[r] <= `RSG_CODE_NONE;
        end
      end
    end
  end

  // ****************************************************************
  // Exit control to the trunks
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_unit_r <= 16'h0;
      rtag_r <= '0;
      op1_r <= '0;
      op2_r <= '0;
    end else if (ce) begin
      go_unit_r <= go_all;
      for (int t = 0; t < 3; t++) begin
        logic [4:0] rt;
        rt = 5'h00;
        op1_r[t] <= 60'h0;
        op2_r[t] <= 60'h0;
        for (int u = 0; u < 16; u++) begin
          if (go_t[t][u]) begin
            rt[`RSG_RT_XF] = u1_r[u] && s1_r[u][4:3] == RSG_GX;
            rt[`RSG_RT_BF] = u1_r[u] && s1_r[u][4:3] == RSG_GB;
            rt[`RSG_RT_AF] = u1_r[u] && s1_r[u][4:3] == RSG_GA;
            rt[`RSG_RT_XS] = u2_r[u] && s2_r[u][4:3] == RSG_GX;
            rt[`RSG_RT_BS] = u2_r[u] && s2_r[u][4:3] == RSG_GB;
            op1_r[t] <= regf_r[s1_r[u]];
            op2_r[t] <= regf_r[s2_r[u]];
          end
        end
        // Trunk one has a single B read path, whichever designator names it.
        if (t == 0) rt[`RSG_RT_BF] = rt[`RSG_RT_BF] | rt[`RSG_RT_BS];
        unique case (t)
          0: rtag_r[t] <= rt & `RSG_RMASK_T1;
          1: rtag_r[t] <= rt & `RSG_RMASK_T2;
          2: rtag_r[t] <= rt & `RSG_RMASK_T3;
        endcase
      end
    end
  end

  // ****************************************************************
  // Release outputs and store-go
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_r <= 16'h0;
      st_tag_r <= '0;
      for (int t = 0; t < 3; t++) st_d_r[t] <= 5'h00;
    end else if (ce) begin
      transmit_r <= fu_grant;
      st_tag_r <= '0;
      for (int u = 0; u < 16; u++) begin
        if (fu_grant[u]) begin
          logic [1:0] tt;
          logic [2:0] sg;
          tt = trunk_of(4'(u)) - 2'd1;
          sg = 3'(3'h1 << res_r[u][4:3]);
          st_d_r[tt] <= res_r[u];
          unique case (tt)
            2'd0: st_tag_r[tt] <= sg & `RSG_SMASK_T1;
            2'd1: st_tag_r[tt] <= sg & `RSG_SMASK_T2;
            2'd2: st_tag_r[tt] <= sg & `RSG_SMASK_T3;
            default: st_tag_r[tt] <= 3'h0;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Entry control and operating registers
  // ****************************************************************
  logic [6:0] wp_v;
  rsg_desig_t wp_i [7];
  rsg_word_t wp_d [7];
  logic dup;
  logic xchg_rd;

  assign xchg_rd = hop_accept && !hop_write;
  assign hif.load = xchg_rd && hop_tag >= `RSG_TAG_RD_LO && hop_tag <= `RSG_TAG_RD_HI;
  assign hif.load_idx = hop_tag[2:0];
  assign hif.load_data = mem_rdata;

  always_comb begin
    logic [23:0] seen;
    seen = 24'h0;
    dup = 1'b0;
    wp_v[0] = xchg_rd && hop_tag[5:3] == `RSG_TAG_XAB;
    wp_i[0] = {RSG_GA, hop_tag[2:0]};
    wp_d[0] = {42'h0, mem_rdata[35:18]};
    wp_v[1] = wp_v[0];
    wp_i[1] = {RSG_GB, hop_tag[2:0]};
    wp_d[1] = {42'h0, mem_rdata[17:0]};
    wp_v[2] = xchg_rd && hop_tag[5:3] == `RSG_TAG_XX;
    wp_i[2] = {RSG_GX, hop_tag[2:0]};
    wp_d[2] = mem_rdata;
    wp_v[3] = hif.move;
    wp_i[3] = {RSG_GX, hif.move_idx};
    wp_d[3] = hif.move_data;
    for (int t = 0; t < 3; t++) begin
      wp_v[4 + t] = |st_tag_r[t];
      wp_i[4 + t] = st_d_r[t];
      if (st_tag_r[t][`RSG_ST_X] && t == 2) begin
        wp_d[4 + t] = {{42{trunk_result[t][17]}}, trunk_result[t][17:0]};
      end else if (st_tag_r[t][`RSG_ST_X]) begin
        wp_d[4 + t] = trunk_result[t];
      end else begin
        wp_d[4 + t] = {42'h0, trunk_result[t][17:0]};
      end
    end
    for (int p = 0; p < 7; p++) begin
      if (wp_v[p]) begin
        if (seen[wp_i[p]]) dup = 1'b1;
        seen[wp_i[p]] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < 24; r++) regf_r[r] <= 60'h0;
    end else if (ce) begin
      for (int p = 0; p < 7; p++) begin
        if (wp_v[p]) regf_r[wp_i[p]] <= wp_d[p];
      end
    end
  end

  rsg_hold u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .hif(hif.hold)
  );

  // Store addresses: the tag goes to exit control and register data to the memory trunk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_v_r <= 1'b0;
      mem_tag_r <= 4'h0;
      mem_wd_r <= 60'h0;
    end else if (ce) begin
      mem_v_r <= 1'b0;
      if (hop_accept && hop_write) begin
        mem_v_r <= 1'b1;
        mem_tag_r <= hop_tag[3:0];
        if (hop_tag[5:3] == `RSG_TAG_XAB) begin
          mem_wd_r <= {24'h0, regf_r[{RSG_GA, hop_tag[2:0]}][17:0],
            regf_r[{RSG_GB, hop_tag[2:0]}][17:0]};
        end else begin
          mem_wd_r <= regf_r[{RSG_GX, hop_tag[2:0]}];
        end
      end
    end
  end

  // ****************************************************************
  // APB registers
  // ****************************************************************
  logic apb_acc;
  assign apb_acc = psel && penable && !pready_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      en_r <= `RSG_CTRL_RST;
      err_r <= 1'b0;
    end else if (ce) begin
      pready_r <= apb_acc;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      // A new conflict wins over a clear written in the same cycle.
      if (apb_acc && pwrite && paddr == `RSG_OFF_CTRL && pwdata[`RSG_CTRL_CLR]) begin
        err_r <= dup;
      end else if (dup) begin
        err_r <= 1'b1;
      end
      if (apb_acc) begin
        if (paddr == `RSG_OFF_CTRL) begin
          if (pwrite) en_r <= pwdata[`RSG_CTRL_EN];
          prdata_r <= {31'h0, en_r};
        end else if (paddr == `RSG_OFF_STAT) begin
          prdata_r <= {14'h0, hif.any_full, err_r, busy_r};
        end else begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign transmit = transmit_r;
  assign go_unit = go_unit_r;
  assign read_tag = rtag_r;
  assign opnd_first = op1_r;
  assign opnd_second = op2_r;
  assign store_tag = st_tag_r;
  assign mem_exit_valid = mem_v_r;
  assign mem_exit_tag = mem_tag_r;
  assign mem_wdata = mem_wd_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_no_hazard_store;
    ce |=> (transmit_r & $past(~all_clear)) == 16'h0;
  endproperty
  a_no_hazard_store: assert property (p_no_hazard_store) else $error("store over waiting read");

  property p_release_cause;
    ce && |rel_cand |=> |transmit_r && (transmit_r & ~$past(rel_req)) == 16'h0;
  endproperty
  a_release_cause: assert property (p_release_cause) else $error("release without request");

  property p_store_go;
    ce && |fu_grant |=> |st_tag_r && (transmit_r & busy_r) == 16'h0;
  endproperty
  a_store_go: assert property (p_store_go) else $error("no store-go with transmit");

  property p_go_flags;
    |go_unit_r |-> (go_unit_r & ~(rf1_r & rf2_r)) == 16'h0;
  endproperty
  a_go_flags: assert property (p_go_flags) else $error("read tags without both flags");

  property p_flags_clear;
    ce && |go_unit_r |=> ((rf1_r | rf2_r) & $past(go_unit_r)) == 16'h0;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("read flags not cleared");

  property p_zero_code;
    ce && !iss_valid && busy_r[1] && !done_r[1] && q1_r[1] == 4'h0 |=> rf1_r[1];
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("free operand flag not set");

  property p_dup_err;
    ce && dup |=> err_r;
  endproperty
  a_dup_err: assert property (p_dup_err) else $error("double write not flagged");

  property p_exit_tag;
    ce && hop_accept && hop_write |=> mem_exit_valid && mem_exit_tag == $past(hop_tag[3:0]);
  endproperty
  a_exit_tag: assert property (p_exit_tag) else $error("exit tag not sent");

  property p_inc_sext;
    ce && st_tag_r[2][0] |=> regf_r[$past(st_d_r[2])][59:18] == {42{$past(trunk_result[2][17])}};
  endproperty
  a_inc_sext: assert property (p_inc_sext) else $error("increment result not extended");
endmodule

// [inc/rsg_defs.svh]
// Constants for the result store and register gating block.
`ifndef RSG_DEFS_SVH
`define RSG_DEFS_SVH
`define RSG_NREG 24
`define RSG_NUNIT 16
`define RSG_NCHAN 5
// Unit codes held in the reservation slots.
`define RSG_CODE_NONE 4'h0
`define RSG_CODE_INC1 4'h1
`define RSG_CODE_INC2 4'h2
`define RSG_CODE_SHIFT 4'h3
`define RSG_CODE_MUL2 4'h7
`define RSG_CODE_CHAN 4'h8
`define RSG_CODE_LADD 4'he
`define RSG_CODE_ADD 4'hf
// Upper octal digit of hopper tags, then the full tag range of holding register loads.
`define RSG_TAG_XAB 3'h6
`define RSG_TAG_XX 3'h7
`define RSG_TAG_STX 3'h2
`define RSG_TAG_RD_LO 6'h09
`define RSG_TAG_RD_HI 6'h0d
// Read tag bits and store tag bits.
`define RSG_RT_XF 0
`define RSG_RT_BF 1
`define RSG_RT_AF 2
`define RSG_RT_XS 3
`define RSG_RT_BS 4
`define RSG_RMASK_T1 5'h0b
`define RSG_RMASK_T2 5'h09
`define RSG_RMASK_T3 5'h17
`define RSG_ST_X 0
`define RSG_ST_B 1
`define RSG_ST_A 2
`define RSG_SMASK_T1 3'h3
`define RSG_SMASK_T2 3'h1
`define RSG_SMASK_T3 3'h7
// Register map.
`define RSG_OFF_CTRL 12'h000
`define RSG_OFF_STAT 12'h004
`define RSG_CTRL_EN 0
`define RSG_CTRL_CLR 1
`define RSG_CTRL_RST 1'h1
`define RSG_STAT_ERR 16
`define RSG_STAT_HOLD 17
`endif

// [inc/rsg_pkg.sv]
// Types shared by the result store and register gating block.
package rsg_pkg;
  typedef logic [4:0] rsg_desig_t;
  typedef logic [3:0] rsg_code_t;
  typedef logic [59:0] rsg_word_t;
  typedef enum logic [1:0] {RSG_GX = 2'b00, RSG_GB = 2'b01, RSG_GA = 2'b10} rsg_grp_t;
  typedef enum logic {RSG_EMPTY = 1'b0, RSG_FULL = 1'b1} rsg_hold_st_t;
endpackage

// [inc/rsg_hold_if.sv]
// Link between the gating logic and the memory operand holding registers.
`timescale 1ns/10ps
interface rsg_hold_if;
  logic load;
  logic [2:0] load_idx;
  rsg_pkg::rsg_word_t load_data;
  logic [7:0] x_clear;
  logic move;
  logic [2:0] move_idx;
  rsg_pkg::rsg_word_t move_data;
  logic any_full;
  modport gate (output load, load_idx, load_data, x_clear, input move, move_idx, move_data,
    any_full);
  modport hold (input load, load_idx, load_data, x_clear, output move, move_idx, move_data,
    any_full);
endinterface

// [src/rsg_hold.sv]
// Holding registers for read-operand data bound for X1 to X5.
`timescale 1ns/10ps
`include "rsg_defs.svh"
module rsg_hold #(
  parameter int NCH = `RSG_NCHAN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  rsg_hold_if.hold hif
);
  import rsg_pkg::*;

  rsg_word_t d_r [1:NCH];
  rsg_hold_st_t st_r [1:NCH];

  // The lowest full holding register whose X target has no reader waiting moves first.
  always_comb begin
    hif.move = 1'b0;
    hif.move_idx = 3'h0;
    hif.any_full = 1'b0;
    for (int n = NCH; n >= 1; n--) begin
      if (st_r[n] == RSG_FULL) begin
        hif.any_full = 1'b1;
        if (hif.x_clear[n]) begin
          hif.move = 1'b1;
          hif.move_idx = 3'(n);
        end
      end
    end
    hif.move_data = d_r[hif.move_idx];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 1; n <= NCH; n++) begin
        st_r[n] <= RSG_EMPTY;
        d_r[n] <= 60'h0;
      end
    end else if (ce) begin
      for (int n = 1; n <= NCH; n++) begin
        unique case (st_r[n])
          RSG_EMPTY: begin
            if (hif.load && hif.load_idx == 3'(n)) begin
              st_r[n] <= RSG_FULL;
              d_r[n] <= hif.load_data;
            end
          end
          RSG_FULL: begin
            if (hif.load && hif.load_idx == 3'(n)) begin
              d_r[n] <= hif.load_data;
            end else if (hif.move && hif.move_idx == 3'(n)) begin
              st_r[n] <= RSG_EMPTY;
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_move_clear;
    hif.move |-> hif.x_clear[hif.move_idx] && st_r[hif.move_idx] == RSG_FULL;
  endproperty
  a_move_clear: assert property (p_move_clear) else $error("operand moved onto busy X");

  property p_load_full;
    ce && hif.load |=> st_r[$past(hif.load_idx)] == RSG_FULL;
  endproperty
  a_load_full: assert property (p_load_full) else $error("holding register not loaded");
endmodule

// [bench/rsg_fu_model.sv]
// Functional unit stand-in that asks for release and drives its data trunk.
`timescale 1ns/10ps
module rsg_fu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] go_unit,
  input wire logic [15:0] transmit,
  input wire logic [59:0] res_val,
  input wire logic [3:0] dly,
  output logic [15:0] rel_req,
  output logic [2:0][59:0] trunk_result
);
  logic [15:0] pend_r;
  logic [3:0] cnt_r;
  // Outside a transmit cycle the trunks carry a shifting inverse, so stale data never matches.
  assign trunk_result = (|transmit) ? {3{res_val}} : {3{~res_val ^ {56'h0, cnt_r}}};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
      cnt_r <= '0;
      rel_req <= '0;
    end else begin
      if (|go_unit) begin
        pend_r <= pend_r | go_unit;
        cnt_r <= dly;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else begin
        pend_r <= pend_r & ~transmit;
      end
      rel_req <= (cnt_r == 4'h0) ? (pend_r & ~transmit) : (rel_req & ~transmit);
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the result store and register gating block.
`timescale 1ns/10ps
module testbench;
  import rsg_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic iss_valid = 0, first_source_used = 0, second_source_used = 0, er;
  rsg_code_t iss_unit = 0;
  rsg_desig_t result_designator = 0, first_source_designator = 0, second_source_designator = 0;
  logic [15:0] rel_req, transmit, go_unit;
  logic [2:0][4:0] read_tag;
  logic [2:0][59:0] opnd_first, opnd_second, trunk_result;
  logic [2:0][2:0] store_tag;
  logic [5:0] hop_tag = 0;
  logic hop_accept = 0, hop_write = 0, mem_exit_valid;
  logic [59:0] mem_rdata = 0, mem_wdata, res_val = 0;
  logic [3:0] mem_exit_tag, dly = 0;
  logic [63:0] r64;
  logic [59:0] xm [16];
  int num_errors = 0, cmp_count = 0, cyc = 0, n;
  int uc[3] = '{15, 7, 1};
  int rd[3] = '{1, 4, 5};
  int sr[3] = '{2, 3, 6};
  int s2[3] = '{7, 7, 11};
  int rte[3] = '{9, 9, 17};
  rsg_gate dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .iss_valid, .iss_unit, .result_designator, .first_source_designator,
    .first_source_used, .second_source_designator, .second_source_used, .rel_req, .transmit,
    .go_unit, .read_tag, .opnd_first, .opnd_second, .store_tag, .trunk_result, .hop_tag,
    .hop_accept, .hop_write, .mem_rdata, .mem_exit_valid, .mem_exit_tag, .mem_wdata);
  rsg_fu_model fu (.pclk, .presetn, .go_unit, .transmit, .res_val, .dly, .rel_req,
    .trunk_result);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ********************************
  // Shared bus and compare tasks
  // ********************************
  task automatic chk(input string nm, input logic [59:0] e, input logic [59:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends when pready goes high; the cycle ceiling of the bench is its only limit.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hop(input logic [5:0] t, input logic w, input logic [59:0] d);
    @(posedge pclk);
    hop_tag <= t;
    hop_write <= w;
    hop_accept <= 1'b1;
    mem_rdata <= d;
    @(posedge pclk);
    hop_accept <= 1'b0;
    mem_rdata <= ~d;
  endtask
  task automatic xread(input logic [5:0] t, input logic [59:0] e);
    int k;
    hop(t, 1'b1, 60'h0);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (mem_exit_valid !== 1'b1 && k < 8);
    chk("exit_tag", {56'h0, t[3:0]}, {56'h0, mem_exit_tag});
    chk("exit_data", e, mem_wdata);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ********************************
  // Tests
  // ********************************
  initial begin
    void'($urandom(10931));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl", 60'h1, {28'h0, q});
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped_err", 60'h1, {59'h0, er});
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      r64 = {$urandom, $urandom};
      xm[i] = (i < 8) ? {24'h0, r64[35:0]} : r64[59:0];
      hop(6'h30 + 6'(i), 1'b0, r64[59:0]);
    end
    for (int i = 0; i < 16; i++) begin
      xread(6'h30 + 6'(i), xm[i]);
    end
    $display("test exchange done");
    r64 = {$urandom, $urandom};
    xm[9] = r64[59:0];
    hop(6'h09, 1'b0, r64[59:0]);
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0000_0000);
      n++;
    end while (q[17] !== 1'b0 && n < 6);
    xread(6'h39, xm[9]);
    $display("test holding done");
    // A holding register move and an exchange load hit X1 in the same cycle.
    r64 = {$urandom, $urandom};
    xm[9] = r64[59:0];
    @(posedge pclk);
    hop_tag <= 6'h09;
    hop_write <= 1'b0;
    hop_accept <= 1'b1;
    mem_rdata <= r64[59:0];
    @(posedge pclk);
    hop_tag <= 6'h39;
    mem_rdata <= ~r64[59:0];
    @(posedge pclk);
    hop_accept <= 1'b0;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("conflict", 60'h1, {59'h0, q[16]});
    apb(1'b1, 12'h000, 32'h0000_0003);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("conflict_clr", 60'h0, {59'h0, q[16]});
    xread(6'h39, xm[9]);
    // With the clock enable low an accepted exchange load must leave X0 alone.
    @(posedge pclk);
    ce <= 1'b0;
    hop(6'h38, 1'b0, 60'h0);
    ce <= 1'b1;
    xread(6'h38, xm[8]);
    $display("test conflict done");
    for (int u = 0; u < 3; u++) begin
      r64 = {$urandom, $urandom};
      @(posedge pclk);
      res_val <= r64[59:0];
      dly <= 4'($urandom % 8);
      iss_valid <= 1'b1;
      iss_unit <= 4'(uc[u]);
      result_designator <= 5'(rd[u]);
      first_source_designator <= 5'(sr[u]);
      first_source_used <= 1'b1;
      second_source_designator <= 5'(s2[u]);
      second_source_used <= 1'b1;
      @(posedge pclk);
      iss_valid <= 1'b0;
      n = 0;
      while (go_unit[uc[u]] !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk("go_unit", 60'h1 << uc[u], {44'h0, go_unit});
      chk("read_tag", 60'(rte[u]), {55'h0, read_tag[u]});
      chk("opnd_first", xm[8 + sr[u]], opnd_first[u]);
      chk("opnd_second", (u == 2) ? {42'h0, xm[3][17:0]} : xm[15], opnd_second[u]);
      n = 0;
      while (transmit[uc[u]] !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk("transmit", 60'h1 << uc[u], {44'h0, transmit});
      chk("store_tag", 60'h1, {57'h0, store_tag[u]});
      xm[8 + rd[u]] = (u == 2) ? {{42{r64[17]}}, r64[17:0]} : r64[59:0];
      xread(6'h38 + 6'(rd[u]), xm[8 + rd[u]]);
    end
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("busy", 60'h0, {44'h0, q[15:0]});
    $display("test release done");
    wrap_up();
  end
endmodule
